// >>> src/mrcr_pkg.sv
// Constants for the monitor result and checksum register slice
package mrcr_pkg;
    // ****************************************************
    // Byte addresses
    // ****************************************************
    localparam logic [7:0] ADDR_RX_WARN_LOW_HIGH = 8'h26;
    localparam logic [7:0] ADDR_RX_WARN_LOW_LOW = 8'h27;
    localparam logic [7:0] ADDR_SUM_BYTE = 8'h5F;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h60;
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h61;
    localparam logic [7:0] ADDR_VOLT_HIGH = 8'h62;
    localparam logic [7:0] ADDR_VOLT_LOW = 8'h63;
    localparam logic [7:0] ADDR_RX_POWER_HIGH = 8'h68;
    localparam logic [7:0] ADDR_RX_POWER_LOW = 8'h69;
    // ****************************************************
    // Reset values and fixed read values
    // ****************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Last byte covered by the sum byte
    localparam int SUM_LAST_BYTE = 94;
    // Data byte width
    localparam int BYTE_W = 8;
endpackage : mrcr_pkg

// >>> src/mrcr_regs.sv
// Monitor result, receive-power low-warning and sum byte register slice
`timescale 1ns/10ps
module mrcr_regs #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Byte register port from the serial bus engine
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [mrcr_pkg::BYTE_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [mrcr_pkg::BYTE_W-1:0] regRdData,
    output logic regAck,
    // Password level
    input wire logic mfrUnlocked,
    // Converter results
    input wire logic [mrcr_pkg::BYTE_W-1:0] tempSample,
    input wire logic [mrcr_pkg::BYTE_W-1:0] voltSample,
    input wire logic [mrcr_pkg::BYTE_W-1:0] rxPowerSample,
    input wire logic conversionDone,
    // Status
    output logic warningFlag,
    output logic resultValid
);
    import mrcr_pkg::*;

    // ****************************************************
    // Elaboration check
    // ****************************************************
    // Byte addresses reach 0x69, so seven bits are the least
    if (ADDR_W < 7 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must be 7 or 8");
    end
    // The sum byte sits right after the bytes that it covers
    if (ADDR_SUM_BYTE != 8'(SUM_LAST_BYTE + 1)) begin : g_bad_sum_addr
        $error("sum byte address must follow the covered range");
    end

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [BYTE_W-1:0] warnHigh;
        logic [BYTE_W-1:0] warnLow;
        logic [BYTE_W-1:0] sumByte;
        logic [BYTE_W-1:0] tempHigh;
        logic [BYTE_W-1:0] voltHigh;
        logic [BYTE_W-1:0] rxHigh;
        logic warn;
        logic valid;
        logic [BYTE_W-1:0] rdData;
        logic ack;
    } mrcr_state_t;

    mrcr_state_t state_r;
    mrcr_state_t state_nxt;
    logic [7:0] addrByte;

    // Widen the port address to a full byte address
    assign addrByte = 8'(regAddr);

    // Sixteen-bit word from a high and low byte
    function automatic logic [15:0] join_word(input logic [7:0] hi, input logic [7:0] lo);
        join_word = {hi, lo};
    endfunction : join_word

    // ****************************************************
    // Next state
    // ****************************************************
    // Read data settles one cycle after the strobe; writes and reads both acknowledge
    always_comb begin
        logic [15:0] warnWord;
        warnWord = 16'h0000;
        state_nxt = state_r;
        state_nxt.ack = regWrite | regRead;
        // Only the high bytes are compared; the low byte is stored for readback
        warnWord = join_word(state_r.warnHigh, state_r.warnLow);
        state_nxt.warn = state_r.rxHigh < warnWord[15:8];
        if (conversionDone) begin
            state_nxt.tempHigh = tempSample;
            state_nxt.voltHigh = voltSample;
            state_nxt.rxHigh = rxPowerSample;
            state_nxt.valid = 1'b1;
        end
        if (regWrite) begin
            unique case (addrByte)
                ADDR_RX_WARN_LOW_HIGH: state_nxt.warnHigh = regWrData;
                ADDR_RX_WARN_LOW_LOW: state_nxt.warnLow = regWrData;
                // Stored as written only when mfrUnlocked, never checked against bytes 0..94
                ADDR_SUM_BYTE: begin
                    if (mfrUnlocked) begin
                        state_nxt.sumByte = regWrData;
                    end
                end
                // Result registers and all else keep their contents
                default: state_nxt.sumByte = state_r.sumByte;
            endcase
        end
        if (regRead) begin
            unique case (addrByte)
                ADDR_RX_WARN_LOW_HIGH: state_nxt.rdData = state_r.warnHigh;
                ADDR_RX_WARN_LOW_LOW: state_nxt.rdData = state_r.warnLow;
                ADDR_SUM_BYTE: state_nxt.rdData = state_r.sumByte;
                ADDR_TEMP_HIGH: state_nxt.rdData = state_r.tempHigh;
                ADDR_TEMP_LOW: state_nxt.rdData = ZERO_BYTE;
                ADDR_VOLT_HIGH: state_nxt.rdData = state_r.voltHigh;
                ADDR_VOLT_LOW: state_nxt.rdData = ZERO_BYTE;
                ADDR_RX_POWER_HIGH: state_nxt.rdData = state_r.rxHigh;
                ADDR_RX_POWER_LOW: state_nxt.rdData = ZERO_BYTE;
                // Unmapped bytes read zero
                default: state_nxt.rdData = ZERO_BYTE;
            endcase
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    // Clock enable low freezes everything, including the acknowledge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r.warnHigh <= RESET_BYTE;
            state_r.warnLow <= RESET_BYTE;
            state_r.sumByte <= RESET_BYTE;
            state_r.tempHigh <= RESET_BYTE;
            state_r.voltHigh <= RESET_BYTE;
            state_r.rxHigh <= RESET_BYTE;
            state_r.warn <= 1'b0;
            state_r.valid <= 1'b0;
            state_r.rdData <= RESET_BYTE;
            state_r.ack <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign regRdData = state_r.rdData;
    assign regAck = state_r.ack;
    assign warningFlag = state_r.warn;
    assign resultValid = state_r.valid;

    // ****************************************************
    // Checks
    // ****************************************************
    a_warn_compare: assert property (@(posedge clock) disable iff (rst)
        ce ##1 ce |-> warningFlag == ($past(state_r.rxHigh) < $past(state_r.warnHigh)))
        else $error("warning flag disagrees with high-byte compare");
    a_low_ignored: assert property (@(posedge clock) disable iff (rst)
        ce ##1 (ce && $stable(state_r.rxHigh) && $stable(state_r.warnHigh)) |=> $stable(warningFlag))
        else $error("warning flag moved with only low byte changing");
    a_sum_locked: assert property (@(posedge clock) disable iff (rst)
        ce && regWrite && addrByte == ADDR_SUM_BYTE && !mfrUnlocked |=> $stable(state_r.sumByte))
        else $error("sum byte written without manufacturer level");
    a_sum_store: assert property (@(posedge clock) disable iff (rst)
        ce && regWrite && addrByte == ADDR_SUM_BYTE && mfrUnlocked |=> state_r.sumByte == $past(regWrData))
        else $error("sum byte not stored");
    a_temp_low_zero: assert property (@(posedge clock) disable iff (rst)
        ce && regRead && addrByte == ADDR_TEMP_LOW |=> regRdData == ZERO_BYTE && regAck)
        else $error("temperature low byte read nonzero");
    a_volt_low_zero: assert property (@(posedge clock) disable iff (rst)
        ce && regRead && addrByte == ADDR_VOLT_LOW |=> regRdData == ZERO_BYTE)
        else $error("supply low byte read nonzero");
    a_temp_read: assert property (@(posedge clock) disable iff (rst)
        ce && regRead && addrByte == ADDR_TEMP_HIGH |=> regRdData == $past(state_r.tempHigh))
        else $error("temperature high byte read wrong");
    a_result_update: assert property (@(posedge clock) disable iff (rst)
        ce && conversionDone |=> resultValid && state_r.voltHigh == $past(voltSample))
        else $error("results not loaded after conversion");
    a_result_ro: assert property (@(posedge clock) disable iff (rst)
        ce && regWrite && !conversionDone && addrByte == ADDR_TEMP_HIGH |=> $stable(state_r.tempHigh) && regAck)
        else $error("result register written or not acknowledged");

    // ****************************************************
    // Further checks on stores, answers and freezing
    // ****************************************************
    // Threshold low byte is kept for read-back only
    a_thr_low_store: assert property (@(posedge clock) disable iff (rst)
        ce && regWrite && addrByte == ADDR_RX_WARN_LOW_LOW |=> state_r.warnLow == $past(regWrData))
        else $error("threshold low byte not stored");

    // Threshold high byte reads back as written
    a_thr_high_read: assert property (@(posedge clock) disable iff (rst)
        ce && regRead && addrByte == ADDR_RX_WARN_LOW_HIGH |=> regRdData == $past(state_r.warnHigh))
        else $error("threshold high byte read wrong");

    // Supply high byte reads the stored result
    a_volt_read: assert property (@(posedge clock) disable iff (rst)
        ce && regRead && addrByte == ADDR_VOLT_HIGH |=> regRdData == $past(state_r.voltHigh))
        else $error("supply high byte read wrong");

    // Temperature high byte follows each finished conversion taken with enable high
    a_temp_load: assert property (@(posedge clock) disable iff (rst)
        ce && conversionDone |=> state_r.tempHigh == $past(tempSample))
        else $error("temperature high byte not loaded");

    // Host writes never reach the supply result
    a_volt_ro: assert property (@(posedge clock) disable iff (rst)
        ce && regWrite && !conversionDone && addrByte == ADDR_VOLT_HIGH |=> $stable(state_r.voltHigh))
        else $error("supply result register written");

    // Sum byte changes only by an accepted host write, never by itself
    a_sum_hold: assert property (@(posedge clock) disable iff (rst)
        ce && !(regWrite && addrByte == ADDR_SUM_BYTE) |=> $stable(state_r.sumByte))
        else $error("sum byte changed without a write");

    // Read data stands until the next read
    a_read_hold: assert property (@(posedge clock) disable iff (rst)
        ce && !regRead |=> $stable(regRdData))
        else $error("read data changed without a read");

    // One acknowledge for every strobe taken with enable high, a cycle later
    a_ack_follows: assert property (@(posedge clock) disable iff (rst)
        ce |=> regAck == $past(regWrite || regRead))
        else $error("acknowledge does not follow the strobe");

    // Once valid, results stay valid until reset
    a_valid_sticky: assert property (@(posedge clock) disable iff (rst)
        resultValid |=> resultValid)
        else $error("result valid flag dropped");

    // A stalled bus engine relies on enable low freezing every register
    a_ce_freeze: assert property (@(posedge clock) disable iff (rst)
        !ce |=> $stable(state_r))
        else $error("state moved with clock enable low");
endmodule : mrcr_regs

// >>> tb/mrcr_host.sv
// Host model issuing byte accesses to the register slice
`timescale 1ns/10ps
module mrcr_host (
    // Clock and answer
    input wire logic clock,
    input wire logic regAck,
    input wire logic [7:0] regRdData,
    // Request
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead
);
    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // One-cycle strobe, answer taken one cycle later; stale address inverted so nothing leans on it
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic k);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = w;
        regRead = !w;
        @(negedge clock);
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        q = regRdData;
        k = regAck;
    endtask : access
endmodule : mrcr_host

// >>> tb/tb_top.sv
// Self-checking bench for the monitor result and sum byte slice
`timescale 1ns/10ps
module tb_top;
    import mrcr_pkg::*;
    logic clock = 1'b0, rst = 1'b1, ce = 1'b1, mfrUnlocked = 1'b0, conversionDone = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData, tempSample = 8'h00, voltSample = 8'h00, rxSample = 8'h00;
    logic regWrite, regRead, regAck, warningFlag, resultValid, k;
    logic [7:0] q, t, v, r, th, sum;
    int numErrors = 0, samplesChecked = 0, cycles = 0;
    // ****************************************************
    // Clock, timeout and instances
    // ****************************************************
    always #20 clock = ~clock;
    // Cut a hang well past the expected few hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            endOfTest();
        end
    end
    mrcr_regs #(.ADDR_W(8)) DUT (.clock(clock), .rst(rst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .regAck(regAck),
        .mfrUnlocked(mfrUnlocked), .tempSample(tempSample), .voltSample(voltSample), .rxPowerSample(rxSample),
        .conversionDone(conversionDone), .warningFlag(warningFlag), .resultValid(resultValid));
    mrcr_host host (.clock(clock), .regAck(regAck), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    // Compare helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q, k);
        chk({7'h00, k}, 8'h01);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, q, k);
        chk({7'h00, k}, 8'h01);
        chk(q, exp);
    endtask : rd
    // Warning level: high byte compare only
    function automatic logic [7:0] expWarn(input logic [7:0] rx, input logic [7:0] thr);
        return {7'h00, rx < thr};
    endfunction : expWarn
    task automatic endOfTest();
        $display("errors %0d, checks %0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : endOfTest
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        void'($urandom(32'h90FC5BFB));
        sum = 8'h00;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        chk({6'h00, resultValid, warningFlag}, 8'h00);
        rd(ADDR_TEMP_HIGH, 8'h00);
        rd(ADDR_VOLT_HIGH, 8'h00);
        rd(ADDR_SUM_BYTE, 8'h00);
        for (int i = 0; i < 10; i++) begin
            t = $urandom;
            v = $urandom;
            r = $urandom;
            th = (i == 0) ? r : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($urandom);
            @(negedge clock);
            {tempSample, voltSample, rxSample, conversionDone} = {t, v, r, 1'b1};
            @(negedge clock);
            {tempSample, voltSample, rxSample, conversionDone} = {~t, ~v, ~r, 1'b0};
            chk({7'h00, resultValid}, 8'h01);
            wr(ADDR_RX_WARN_LOW_HIGH, th);
            wr(ADDR_RX_WARN_LOW_LOW, (i == 3) ? 8'h00 : 8'($urandom));
            wr(ADDR_TEMP_HIGH + 8'(i % 4), ~t);
            chk({7'h00, warningFlag}, expWarn(r, th));
            rd(ADDR_TEMP_HIGH, t);
            rd(ADDR_TEMP_LOW, 8'h00);
            rd(ADDR_VOLT_HIGH, v);
            rd(ADDR_VOLT_LOW, 8'h00);
            rd(ADDR_RX_POWER_HIGH, r);
            mfrUnlocked = i[0];
            wr(ADDR_SUM_BYTE, 8'(i * 37 + 5));
            if (i[0]) sum = 8'(i * 37 + 5);
            rd(ADDR_SUM_BYTE, sum);
        end
        rd(8'h70, 8'h00);
        // Enable low loses a strobe and a conversion; a spare cycle lets the last acknowledge end first
        @(negedge clock);
        ce = 1'b0;
        {tempSample, voltSample, rxSample, conversionDone} = {~t, ~v, ~r, 1'b1};
        host.access(1'b1, ADDR_RX_WARN_LOW_HIGH, ~th, q, k);
        {ce, conversionDone} = 2'b10;
        chk({7'h00, k}, 8'h00);
        chk({7'h00, warningFlag}, expWarn(r, th));
        rd(ADDR_TEMP_HIGH, t);
        rd(ADDR_RX_WARN_LOW_HIGH, th);
        // Second reset in mid-run clears results, flags and the sum byte
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        chk({6'h00, resultValid, warningFlag}, 8'h00);
        rd(ADDR_TEMP_HIGH, 8'h00);
        rd(ADDR_SUM_BYTE, 8'h00);
        endOfTest();
    end
endmodule : tb_top
